//--- shared/dcp_agent_pkg.sv
package dcp_agent_pkg;

  // ****************************************************************
  // Message coding
  // ****************************************************************
  localparam logic [4:0] MT_NONE      = 5'h00;
  localparam logic [4:0] MT_INIT_DISC = 5'h01;
  localparam logic [4:0] MT_DISC      = 5'h02;
  localparam logic [4:0] MT_RESET     = 5'h03;
  localparam logic [4:0] MT_VR_READ   = 5'h05;
  localparam logic [4:0] MT_VR_WRITE  = 5'h06;
  localparam logic [4:0] MT_EVENT     = 5'h08;

  localparam logic DIR_TO_DEV  = 1'b1;
  localparam logic DIR_TO_CTRL = 1'b0;

  localparam logic [3:0] PORT_MAIN = 4'h1;
  localparam logic [3:0] PORT_ALL  = 4'hF;

  // Largest number of 32-bit words that fit in one cell payload
  localparam logic [3:0] VR_MAX_WORDS = 4'h8;

  // ****************************************************************
  // Virtual register indices
  // ****************************************************************
  localparam logic [7:0] VR_CTRL    = 8'h00;
  localparam logic [7:0] VR_SOFT    = 8'h01;
  localparam logic [7:0] VR_WIDE_LO = 8'h02;
  localparam logic [7:0] VR_WIDE_HI = 8'h03;
  localparam logic [7:0] VR_STATUS  = 8'h04;
  localparam logic [7:0] VR_ALIAS   = 8'h05;
  localparam int         SOFT_BIT   = 0;
  localparam logic [31:0] VREG_RST  = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ          = 125;
  localparam int EV_CLEAR_US      = 1000;
  localparam int EV_CLEAR_CYCLES  = EV_CLEAR_US * CLK_MHZ;
  localparam int DISC_DELAY_W     = 8;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // ****************************************************************
  // Message carriers
  // ****************************************************************
  typedef struct packed {
    logic       dest;
    logic       ack_req;
    logic       ack;
    logic [4:0] msg_type;
    logic [15:0] trans_id;
    logic [7:0] vr_index;
    logic [3:0] vr_count;
    logic [3:0] port_mask;
  } hdr_type;

  typedef struct packed {
    hdr_type     hdr;
    logic [31:0] data;
    logic        last;
  } beat_type;

endpackage

//--- hdl/dcp_msg_agent.sv
`timescale 1ns/1ns
module dcp_msg_agent #(
  parameter logic [31:0] DEVICE_ID       = 32'h0D0C_0001, // Arbitrary value
  parameter logic [15:0] LFSR_SEED       = 16'h1ACE,
  parameter int          VREG_DEPTH      = 16,
  parameter logic [3:0]  EV_MAX_OUT      = 4'h4,
  parameter logic        EV_ACK_REQ      = 1'b1,
  parameter int          EV_CLEAR_CYCLES = dcp_agent_pkg::EV_CLEAR_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    rx_valid,
  output logic                         rx_ready,
  input  wire dcp_agent_pkg::beat_type rx_beat,
  output logic                         tx_valid,
  input  wire logic                    tx_ready,
  output dcp_agent_pkg::beat_type      tx_beat,
  input  wire logic                    event_valid,
  input  wire logic [7:0]              event_code,
  output logic                         soft_reset
);

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_READ = 1'b1
  } state_type;

  // ****************************************************************
  // State
  // ****************************************************************
  state_type   state;
  state_type   next_state;
  logic        msg_rst;
  logic        soft_clr;
  logic [15:0] lfsr;
  logic        disc_pend;
  logic [7:0]  disc_wait;
  logic [15:0] own_tid;
  logic [3:0]  wr_cnt;
  logic [7:0]  rd_ptr;
  logic [3:0]  rd_left;
  logic [3:0]  rd_count;
  logic [15:0] rd_tid;
  logic [63:0] uptime;
  logic [31:0] wide_hold;
  logic [31:0] snap_hi;
  logic        ev_pend;
  logic [7:0]  ev_code;
  logic [31:0] ev_last_data;
  logic [3:0]  ev_out;
  logic [31:0] ev_timer;
  logic [31:0] vreg [VREG_DEPTH];

  logic                    next_tx_valid;
  dcp_agent_pkg::beat_type next_tx_beat;
  logic                    launch_disc;
  logic                    launch_ev;
  logic                    rd_step;

  // ****************************************************************
  // Receive decode
  // ****************************************************************
  localparam logic [8:0] DEPTH_L = 9'(VREG_DEPTH);
  localparam int         IDX_W   = $clog2(VREG_DEPTH);
  localparam logic [31:0] EV_LAST_TICK = 32'(EV_CLEAR_CYCLES - 1);

  dcp_agent_pkg::hdr_type rh;
  wire clear    = sys_rst | msg_rst;
  wire tx_free  = ~tx_valid | tx_ready;
  wire rx_fire  = rx_valid & rx_ready;
  wire to_dev   = rx_beat.hdr.dest == dcp_agent_pkg::DIR_TO_DEV;
  wire rx_ok    = rx_fire & to_dev;
  wire is_init  = rx_ok & (rh.msg_type == dcp_agent_pkg::MT_INIT_DISC)
                  & ~rh.ack;
  wire is_dack  = rx_ok & (rh.msg_type == dcp_agent_pkg::MT_DISC) & rh.ack;
  wire is_reset = rx_ok & (rh.msg_type == dcp_agent_pkg::MT_RESET)
                  & ~rh.ack;
  wire is_read  = rx_ok & (rh.msg_type == dcp_agent_pkg::MT_VR_READ)
                  & ~rh.ack & (rh.vr_count != 4'h0);
  wire is_write = rx_ok & (rh.msg_type == dcp_agent_pkg::MT_VR_WRITE)
                  & ~rh.ack;
  wire is_evack = rx_ok & (rh.msg_type == dcp_agent_pkg::MT_EVENT)
                  & rh.ack;
  // Anything else falls through with no effect
  wire known    = is_init | is_dack | is_reset | is_read | is_write
                  | is_evack;
  assign rh = rx_beat.hdr;

  // ****************************************************************
  // Virtual register write path
  // ****************************************************************
  wire [7:0] wr_idx  = 8'(rh.vr_index + {4'h0, wr_cnt});
  wire       wr_ok   = is_write & (wr_cnt < dcp_agent_pkg::VR_MAX_WORDS);
  wire [7:0] wr_map  = (wr_idx == dcp_agent_pkg::VR_ALIAS) ?
                       dcp_agent_pkg::VR_CTRL : wr_idx;
  wire       wr_rng  = {1'b0, wr_map} < DEPTH_L;
  wire       wr_soft = wr_ok & (wr_map == dcp_agent_pkg::VR_SOFT)
                       & rx_beat.data[dcp_agent_pkg::SOFT_BIT];
  wire       wr_lo   = wr_ok & (wr_map == dcp_agent_pkg::VR_WIDE_LO);
  wire       wr_hi   = wr_ok & (wr_map == dcp_agent_pkg::VR_WIDE_HI);
  wire       wr_ro   = (wr_map == dcp_agent_pkg::VR_SOFT)
                       | (wr_map == dcp_agent_pkg::VR_WIDE_LO)
                       | (wr_map == dcp_agent_pkg::VR_WIDE_HI)
                       | (wr_map == dcp_agent_pkg::VR_STATUS);
  wire       st_en   = wr_ok & wr_rng & ~wr_ro;
  wire       wr_ackd = is_write & rx_beat.last & rh.ack_req;

  // ****************************************************************
  // Virtual register read path
  // ****************************************************************
  wire [7:0]  rd_map = (rd_ptr == dcp_agent_pkg::VR_ALIAS) ?
                       dcp_agent_pkg::VR_CTRL : rd_ptr;
  wire        rd_rng = {1'b0, rd_map} < DEPTH_L;
  wire        rd_lo  = rd_map == dcp_agent_pkg::VR_WIDE_LO;
  wire [31:0] status = {20'h0, 3'h0, disc_pend, 4'h0, ev_out};
  // Out-of-range indices read back as zero
  wire [31:0] rd_word =
    !rd_rng                                ? 32'h0000_0000 :
    rd_lo                                  ? uptime[31:0] :
    (rd_map == dcp_agent_pkg::VR_WIDE_HI)  ? snap_hi :
    (rd_map == dcp_agent_pkg::VR_STATUS)   ? status :
    (rd_map == dcp_agent_pkg::VR_SOFT)     ? 32'h0000_0000 :
                                             vreg[rd_map[IDX_W-1:0]];
  wire [3:0]  rd_cnt_in = (rh.vr_count > dcp_agent_pkg::VR_MAX_WORDS) ?
                          dcp_agent_pkg::VR_MAX_WORDS : rh.vr_count;

  // ****************************************************************
  // Discovery and event scheduling
  // ****************************************************************
  wire disc_go   = disc_pend & (disc_wait == 8'h00);
  wire ev_go     = ev_pend & (ev_out < EV_MAX_OUT);
  wire ev_tick   = ev_timer == EV_LAST_TICK;
  wire ev_match  = is_evack & (rx_beat.data == ev_last_data)
                   & (ev_out != 4'h0);
  wire ev_count  = launch_ev & EV_ACK_REQ;
  wire ev_take   = event_valid & (~ev_pend | launch_ev);
  wire [15:0] lfsr_nx = lfsr[0] ? ((lfsr >> 1) ^ dcp_agent_pkg::LFSR_TAPS)
                                : (lfsr >> 1);

  // ****************************************************************
  // Transmit selection
  // ****************************************************************
  always_comb begin
    next_tx_valid = tx_valid & ~tx_ready;
    next_tx_beat  = tx_beat;
    next_state    = state;
    launch_disc   = 1'b0;
    launch_ev     = 1'b0;
    rd_step       = 1'b0;
    if (state == ST_READ) begin
      if (tx_free) begin
        rd_step                    = 1'b1;
        next_tx_valid              = 1'b1;
        next_tx_beat.hdr           = '{dcp_agent_pkg::DIR_TO_CTRL, 1'b0,
                                       1'b1, dcp_agent_pkg::MT_VR_READ,
                                       rd_tid, rd_ptr, rd_count,
                                       dcp_agent_pkg::PORT_MAIN};
        next_tx_beat.data          = rd_word;
        next_tx_beat.last          = rd_left == 4'h1;
        if (rd_left == 4'h1) begin
          next_state = ST_IDLE;
        end
      end
    end else if (rx_fire) begin
      if (is_read) begin
        next_state = ST_READ;
      end else if (is_init) begin
        next_tx_valid     = 1'b1;
        next_tx_beat.hdr  = '{dcp_agent_pkg::DIR_TO_CTRL, 1'b1, 1'b1,
                              dcp_agent_pkg::MT_DISC, rh.trans_id, 8'h00,
                              4'h0, dcp_agent_pkg::PORT_MAIN};
        next_tx_beat.data = DEVICE_ID;
        next_tx_beat.last = 1'b1;
      end else if (wr_ackd) begin
        next_tx_valid     = 1'b1;
        next_tx_beat.hdr  = '{dcp_agent_pkg::DIR_TO_CTRL, 1'b0, 1'b1,
                              dcp_agent_pkg::MT_VR_WRITE, rh.trans_id,
                              rh.vr_index, rh.vr_count,
                              dcp_agent_pkg::PORT_MAIN};
        next_tx_beat.data = 32'h0000_0000;
        next_tx_beat.last = 1'b1;
      end
    end else if (!tx_valid && !msg_rst) begin
      // Nothing new starts while a reset message clears the block
      if (disc_go) begin
        launch_disc       = 1'b1;
        next_tx_valid     = 1'b1;
        next_tx_beat.hdr  = '{dcp_agent_pkg::DIR_TO_CTRL, 1'b1, 1'b0,
                              dcp_agent_pkg::MT_DISC, own_tid, 8'h00, 4'h0,
                              dcp_agent_pkg::PORT_ALL};
        next_tx_beat.data = DEVICE_ID;
        next_tx_beat.last = 1'b1;
      end else if (ev_go) begin
        launch_ev         = 1'b1;
        next_tx_valid     = 1'b1;
        next_tx_beat.hdr  = '{dcp_agent_pkg::DIR_TO_CTRL, EV_ACK_REQ, 1'b0,
                              dcp_agent_pkg::MT_EVENT, own_tid, 8'h00,
                              4'h0, dcp_agent_pkg::PORT_MAIN};
        next_tx_beat.data = {24'h00_0000, ev_code};
        next_tx_beat.last = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      msg_rst <= 1'b0;
      lfsr    <= LFSR_SEED;
    end else begin
      msg_rst <= is_reset;
      lfsr    <= lfsr_nx;
    end
  end

  // A reset message rebuilds everything below from scratch
  always_ff @(posedge core_clk) begin
    if (clear) begin
      state    <= ST_IDLE;
      tx_valid <= 1'b0;
      tx_beat  <= '0;
      rx_ready <= 1'b0;
      own_tid  <= 16'h0000;
    end else begin
      state    <= next_state;
      tx_valid <= next_tx_valid;
      tx_beat  <= next_tx_beat;
      rx_ready <= (next_state == ST_IDLE) & ~next_tx_valid & ~is_reset;
      if (launch_disc || launch_ev) begin
        own_tid <= 16'(own_tid + 16'h0001);
      end
    end
  end

  // Random offset spreads replies of many devices after reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      disc_pend <= 1'b1;
      disc_wait <= LFSR_SEED[dcp_agent_pkg::DISC_DELAY_W-1:0];
    end else if (msg_rst) begin
      disc_pend <= 1'b1;
      disc_wait <= lfsr[dcp_agent_pkg::DISC_DELAY_W-1:0];
    end else begin
      if (launch_disc) begin
        disc_pend <= 1'b0;
      end
      if (disc_wait != 8'h00) begin
        disc_wait <= disc_wait - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear) begin
      wr_cnt   <= 4'h0;
      rd_ptr   <= 8'h00;
      rd_left  <= 4'h0;
      rd_count <= 4'h0;
      rd_tid   <= 16'h0000;
      snap_hi  <= 32'h0000_0000;
    end else begin
      if (is_write) begin
        wr_cnt <= rx_beat.last ? 4'h0 : 4'(wr_cnt + 4'h1);
      end
      if (is_read) begin
        rd_ptr   <= rh.vr_index;
        rd_left  <= rd_cnt_in;
        rd_count <= rd_cnt_in;
        rd_tid   <= rh.trans_id;
      end else if (rd_step) begin
        rd_ptr  <= 8'(rd_ptr + 8'h01);
        rd_left <= 4'(rd_left - 4'h1);
      end
      // Low half read freezes the high half of the same value
      if (rd_step && rd_lo) begin
        snap_hi <= uptime[63:32];
      end
    end
  end

  // 64-bit counter written whole when its high half arrives
  always_ff @(posedge core_clk) begin
    if (clear) begin
      uptime    <= 64'h0;
      wide_hold <= 32'h0000_0000;
    end else if (wr_hi) begin
      uptime <= {rx_beat.data, wide_hold};
    end else begin
      uptime <= 64'(uptime + 64'h1);
      if (wr_lo) begin
        wide_hold <= rx_beat.data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear) begin
      soft_clr <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      soft_clr <= wr_soft;
      soft_reset <= wr_soft;
    end
  end

  // ****************************************************************
  // Event notification bookkeeping
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (clear) begin
      ev_pend      <= 1'b0;
      ev_code      <= 8'h00;
      ev_last_data <= 32'h0000_0000;
    end else begin
      if (ev_take) begin
        ev_pend <= 1'b1;
        ev_code <= event_code;
      end else if (launch_ev) begin
        ev_pend <= 1'b0;
      end
      if (launch_ev) begin
        ev_last_data <= {24'h00_0000, ev_code};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear || soft_clr) begin
      ev_out   <= 4'h0;
      ev_timer <= 32'h0000_0000;
    end else if (ev_tick) begin
      // A notice launched on the clearing tick still counts
      ev_out   <= {3'h0, ev_count};
      ev_timer <= 32'h0000_0000;
    end else begin
      ev_timer <= 32'(ev_timer + 32'h1);
      if (ev_count && !ev_match) begin
        ev_out <= 4'(ev_out + 4'h1);
      end else if (ev_match && !ev_count) begin
        ev_out <= 4'(ev_out - 4'h1);
      end
    end
  end

  // ****************************************************************
  // Virtual register storage
  // ****************************************************************
  for (genvar i = 0; i < VREG_DEPTH; i++) begin : g_vreg
    always_ff @(posedge core_clk) begin
      if (clear || soft_clr) begin
        vreg[i] <= dcp_agent_pkg::VREG_RST;
      end else if (st_en && wr_map == 8'(i)) begin
        vreg[i] <= rx_beat.data;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_reset_msg;
    is_reset ##1 msg_rst;
  endsequence

  property p_init_reply;
    is_init |=> tx_valid && tx_beat.hdr.msg_type == dcp_agent_pkg::MT_DISC
      && tx_beat.hdr.ack && tx_beat.hdr.trans_id == $past(rh.trans_id)
      && tx_beat.data == DEVICE_ID;
  endproperty
  a_init_reply: assert property (p_init_reply)
    else $error("Initiate discover not answered");

  property p_init_no_reset;
    is_init && !msg_rst |=> !msg_rst ##1 !soft_reset;
  endproperty
  a_init_no_reset: assert property (p_init_no_reset)
    else $error("Discovery request caused a reset");

  property p_reset_discover;
    s_reset_msg |=> disc_pend && state == ST_IDLE && !tx_valid;
  endproperty
  a_reset_discover: assert property (p_reset_discover)
    else $error("Reset message did not rearm discovery");

  property p_no_reset_out;
    tx_valid |-> tx_beat.hdr.msg_type != dcp_agent_pkg::MT_RESET
      && tx_beat.hdr.dest == dcp_agent_pkg::DIR_TO_CTRL;
  endproperty
  a_no_reset_out: assert property (p_no_reset_out)
    else $error("Bad outbound type or direction");

  property p_discard;
    rx_fire && !known && state == ST_IDLE |=> state == ST_IDLE
      && !tx_valid && !msg_rst;
  endproperty
  a_discard: assert property (p_discard)
    else $error("Unsupported message changed state");

  property p_read_burst;
    is_read && rh.vr_count == 4'h1 |=> state == ST_READ
      ##1 tx_valid && tx_beat.last && state == ST_IDLE;
  endproperty
  a_read_burst: assert property (p_read_burst)
    else $error("Single-word read reply wrong");

  property p_event_cap;
    ev_out <= EV_MAX_OUT;
  endproperty
  a_event_cap: assert property (p_event_cap)
    else $error("Outstanding events over cap");

  property p_ev_match;
    ev_match && !ev_count && !ev_tick && !soft_clr && !msg_rst
      |=> ev_out == 4'($past(ev_out) - 4'h1);
  endproperty
  a_ev_match: assert property (p_ev_match)
    else $error("Matched event ack not counted");

  property p_ev_header;
    launch_ev |=> tx_valid && tx_beat.hdr.ack_req == EV_ACK_REQ
      && !tx_beat.hdr.ack && tx_beat.data[31:8] == 24'h00_0000;
  endproperty
  a_ev_header: assert property (p_ev_header)
    else $error("Event header flags wrong");

endmodule // dcp_msg_agent

//--- tb/ctrl_sink_model.sv
`timescale 1ns/1ns
// ****************
// Controller side of the outbound channel, prompt or stalling
// ****************
module ctrl_sink_model (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic slow,
  output logic      tx_ready
);
  initial tx_ready = 1'b0;
  always @(posedge core_clk) begin
    #1;
    if (sys_rst) tx_ready = 1'b0;
    else if (slow) tx_ready = ($urandom % 4) == 0;
    else tx_ready = ($urandom % 4) != 0;
  end
endmodule // ctrl_sink_model

//--- tb/device_control_message_agent_test.sv
`timescale 1ns/1ns
module device_control_message_agent_test;
  typedef struct packed {
    logic [4:0] mt; logic ak; logic ar; logic [3:0] pm; logic [15:0] tid;
    logic [31:0] d; logic last; logic ct; logic cd;
  } note_type;
  logic core_clk, sys_rst, rx_valid, rx_ready, tx_valid, tx_ready;
  logic event_valid, soft_reset, slow;
  logic [7:0] event_code;
  dcp_agent_pkg::beat_type rx_beat, tx_beat;
  int mismatches, checks, cycles, pulses;
  note_type q[$];
  note_type n;
  logic [31:0] w[8];
  logic [15:0] t;
  logic [7:0] code[5];
  // Arbitrary identity value handed to the device
  localparam logic [31:0] DEV_ID = 32'h5A17_00C3;

  dcp_msg_agent #(.DEVICE_ID(DEV_ID), .EV_CLEAR_CYCLES(20000)) i_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_beat(rx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_beat(tx_beat), .event_valid(event_valid), .event_code(event_code),
    .soft_reset(soft_reset));
  ctrl_sink_model i_sink (.core_clk(core_clk), .sys_rst(sys_rst),
    .slow(slow), .tx_ready(tx_ready));

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic send(input logic [4:0] mt, input logic ar, input logic ak,
      input logic [7:0] idx, input logic [3:0] cnt, input logic [31:0] d,
      input logic l, input logic dst);
    rx_beat = '{'{dst, ar, ak, mt, t, idx, cnt, 4'h0}, d, l};
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1) tick(1);
    tick(1);
    rx_valid = 1'b0;
    tick(1);
  endtask
  task automatic expect_beat(input logic [4:0] mt, input logic ak,
      input logic ar, input logic [3:0] pm, input logic [31:0] d,
      input logic l, input logic ct, input logic cd);
    q.push_back('{mt, ak, ar, pm, t, d, l, ct, cd});
  endtask
  task automatic drain;
    while (q.size() != 0) tick(1);
    tick(4);
  endtask
  task automatic vr_write(input logic [7:0] idx, input int k);
    for (int i = 0; i < k; i++)
      send(dcp_agent_pkg::MT_VR_WRITE, 1'b0, 1'b0, idx, 4'(k), w[i],
           i == k - 1, dcp_agent_pkg::DIR_TO_DEV);
  endtask
  task automatic vr_read(input logic [7:0] idx, input int k);
    t = 16'($urandom);
    for (int i = 0; i < k; i++)
      expect_beat(dcp_agent_pkg::MT_VR_READ, 1'b1, 1'b0, 4'h0, w[i],
                  i == k - 1, 1'b1, 1'b1);
    send(dcp_agent_pkg::MT_VR_READ, 1'b1, 1'b0, idx, 4'(k), 32'h0, 1'b1,
         dcp_agent_pkg::DIR_TO_DEV);
    drain;
  endtask

  // ****************
  // Outbound monitor and scoreboard
  // ****************
  // Ceiling well above the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict;
    end
  end

  always @(posedge core_clk) begin
    if (soft_reset === 1'b1) pulses++;
    if (!sys_rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (q.size() == 0) check(32'h1, 32'h0);
      else begin
        n = q.pop_front();
        check(tx_beat.hdr.msg_type, n.mt);
        check(tx_beat.hdr.ack, n.ak);
        check(tx_beat.hdr.ack_req, n.ar);
        check(tx_beat.hdr.dest, dcp_agent_pkg::DIR_TO_CTRL);
        check(tx_beat.last, n.last);
        if (n.ct) check(tx_beat.hdr.trans_id, n.tid);
        if (n.cd) check(tx_beat.data, n.d);
        if (n.mt == dcp_agent_pkg::MT_DISC)
          check(tx_beat.hdr.port_mask, n.pm);
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    sys_rst = 1'b1; rx_valid = 1'b0; rx_beat = '0; event_valid = 1'b0;
    event_code = 8'h00; slow = 1'b0; mismatches = 0; checks = 0;
    cycles = 0; pulses = 0; t = 16'h0000;
    void'($urandom(83490));
    tick(16);
    sys_rst = 1'b0;
    expect_beat(dcp_agent_pkg::MT_DISC, 1'b0, 1'b1, dcp_agent_pkg::PORT_ALL,
                DEV_ID, 1'b1, 1'b0, 1'b1);
    drain;
    t = 16'($urandom);
    send(dcp_agent_pkg::MT_DISC, 1'b0, 1'b1, 8'h00, 4'h0, 32'h0, 1'b1,
         dcp_agent_pkg::DIR_TO_DEV);
    w[0] = 32'($urandom % 256);
    vr_write(dcp_agent_pkg::VR_CTRL, 1);
    t = 16'($urandom);
    expect_beat(dcp_agent_pkg::MT_DISC, 1'b1, 1'b1, dcp_agent_pkg::PORT_MAIN,
                DEV_ID, 1'b1, 1'b1, 1'b1);
    send(dcp_agent_pkg::MT_INIT_DISC, 1'b1, 1'b0, 8'h00, 4'h0, 32'h0, 1'b1,
         dcp_agent_pkg::DIR_TO_DEV);
    drain;
    foreach (code[k]) begin
      code[k] = k == 0 ? 8'h00 : k == 1 ? 8'h04 : k == 2 ? 8'h07 :
                k == 3 ? 8'h09 : 8'h1F;
      send(5'(code[k]), 1'b1, 1'b0, dcp_agent_pkg::VR_CTRL, 4'h1, ~w[0],
           1'b1, dcp_agent_pkg::DIR_TO_DEV);
    end
    send(dcp_agent_pkg::MT_VR_WRITE, 1'b0, 1'b0, dcp_agent_pkg::VR_CTRL,
         4'h1, ~w[0], 1'b1, dcp_agent_pkg::DIR_TO_CTRL);
    send(dcp_agent_pkg::MT_VR_READ, 1'b1, 1'b0, dcp_agent_pkg::VR_CTRL,
         4'h0, 32'h0, 1'b1, dcp_agent_pkg::DIR_TO_DEV);
    tick(10);
    vr_read(dcp_agent_pkg::VR_CTRL, 1);
    vr_read(dcp_agent_pkg::VR_ALIAS, 1);
    // Acknowledged two-word write commits the whole wide counter
    t = 16'($urandom);
    w[1] = $urandom;
    expect_beat(dcp_agent_pkg::MT_VR_WRITE, 1'b1, 1'b0, 4'h0, 32'h0, 1'b1,
                1'b1, 1'b1);
    send(dcp_agent_pkg::MT_VR_WRITE, 1'b1, 1'b0, dcp_agent_pkg::VR_WIDE_LO,
         4'h2, 32'h0, 1'b0, dcp_agent_pkg::DIR_TO_DEV);
    send(dcp_agent_pkg::MT_VR_WRITE, 1'b1, 1'b0, dcp_agent_pkg::VR_WIDE_LO,
         4'h2, w[1], 1'b1, dcp_agent_pkg::DIR_TO_DEV);
    drain;
    t = 16'($urandom);
    expect_beat(dcp_agent_pkg::MT_VR_READ, 1'b1, 1'b0, 4'h0, 32'h0, 1'b0,
                1'b1, 1'b0);
    expect_beat(dcp_agent_pkg::MT_VR_READ, 1'b1, 1'b0, 4'h0, w[1], 1'b1,
                1'b1, 1'b1);
    send(dcp_agent_pkg::MT_VR_READ, 1'b1, 1'b0, dcp_agent_pkg::VR_WIDE_LO,
         4'h2, 32'h0, 1'b1, dcp_agent_pkg::DIR_TO_DEV);
    drain;
    slow = 1'b1;
    for (int i = 0; i < 8; i++) w[i] = $urandom;
    vr_write(8'h06, 8);
    vr_read(8'h06, 8);
    slow = 1'b0;
    w[0] = 32'h0000_0001;
    vr_write(dcp_agent_pkg::VR_SOFT, 1);
    tick(4);
    check(32'(pulses), 32'h1);
    w[0] = dcp_agent_pkg::VREG_RST;
    vr_read(8'h06, 1);
    w[0] = $urandom;
    vr_write(dcp_agent_pkg::VR_CTRL, 1);
    expect_beat(dcp_agent_pkg::MT_DISC, 1'b0, 1'b1, dcp_agent_pkg::PORT_ALL,
                DEV_ID, 1'b1, 1'b0, 1'b1);
    send(dcp_agent_pkg::MT_RESET, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0, 1'b1,
         dcp_agent_pkg::DIR_TO_DEV);
    drain;
    w[0] = dcp_agent_pkg::VREG_RST;
    vr_read(dcp_agent_pkg::VR_CTRL, 1);
    foreach (code[k]) begin
      code[k] = 8'($urandom);
      if (k < 4)
        expect_beat(dcp_agent_pkg::MT_EVENT, 1'b0, 1'b1, 4'h0,
                    {24'h0, code[k]}, 1'b1, 1'b0, 1'b1);
      event_valid = 1'b1;
      event_code = code[k];
      tick(1);
      event_valid = 1'b0;
      if (k < 4) drain;
      else tick(8);
    end
    w[0] = 32'h0000_0004;
    vr_read(dcp_agent_pkg::VR_STATUS, 1);
    send(dcp_agent_pkg::MT_EVENT, 1'b0, 1'b1, 8'h00, 4'h0,
         {24'h0, code[3] ^ 8'h01}, 1'b1, dcp_agent_pkg::DIR_TO_DEV);
    tick(20);
    expect_beat(dcp_agent_pkg::MT_EVENT, 1'b0, 1'b1, 4'h0, {24'h0, code[4]},
                1'b1, 1'b0, 1'b1);
    send(dcp_agent_pkg::MT_EVENT, 1'b0, 1'b1, 8'h00, 4'h0, {24'h0, code[3]},
         1'b1, dcp_agent_pkg::DIR_TO_DEV);
    drain;
    vr_read(dcp_agent_pkg::VR_STATUS, 1);
    tick(20000);
    w[0] = 32'h0000_0000;
    vr_read(dcp_agent_pkg::VR_STATUS, 1);
    print_verdict;
  end
endmodule // device_control_message_agent_test
